// File: hw/nfcmc_pkg.sv
package nfcmc_pkg;

    // ------------------------------------------------------------
    // Bit rates
    // ------------------------------------------------------------
    localparam logic [1:0] RATE_106 = 2'h0;
    localparam logic [1:0] RATE_212 = 2'h1;
    localparam logic [1:0] RATE_424 = 2'h2;
    localparam logic [1:0] RATE_848 = 2'h3;

    // ------------------------------------------------------------
    // Bit coding and modulation codes
    // ------------------------------------------------------------
    localparam logic [1:0] CODE_NONE   = 2'h0;
    localparam logic [1:0] CODE_MILLER = 2'h1;
    localparam logic [1:0] CODE_MANCH  = 2'h2;
    localparam logic [1:0] MOD_NONE    = 2'h0;
    localparam logic [1:0] MOD_ASK100  = 2'h1;
    localparam logic [1:0] MOD_ASK_LOW = 2'h2;
    localparam logic [1:0] MOD_LOAD    = 2'h3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int INITIAL_FIELD_CHECK_DELAY_NS = 5000;
    localparam int INITIAL_FIELD_CHECK_DELAY_CYC =
        (INITIAL_FIELD_CHECK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Field status bits and reset values
    // ------------------------------------------------------------
    localparam int FST_OWN = 0;
    localparam int FST_EXT = 1;
    localparam int FST_ERR = 2;
    localparam logic [2:0] FIELD_STATUS_RST = 3'h0;
    localparam logic [15:0] CNT_RST = 16'h0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] tx_code;
        logic [1:0] rx_code;
        logic [1:0] tx_mod;
        logic       own_field;
    } nfcmc_cfg_t;

    typedef struct packed {
        logic manch;
        logic type_a;
    } nfcmc_md_t;

    typedef enum logic [2:0] {
        FS_OFF   = 3'h1,
        FS_CHECK = 3'h2,
        FS_ON    = 3'h4
    } nfcmc_fs_t;

    typedef enum logic [2:0] {
        CS_IDLE   = 3'h1,
        CS_READY  = 3'h2,
        CS_ACTIVE = 3'h4
    } nfcmc_cs_t;

endpackage

// File: hw/nfcmc_core.sv
`timescale 1ns/1ps
module nfcmc_core
    import nfcmc_pkg::*;
#(
    parameter int CHECK_CYC = INITIAL_FIELD_CHECK_DELAY_CYC
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    // Host control
    input  wire logic       i_init_request,
    input  wire logic       i_field_on_instruction,
    input  wire logic       i_field_off_instruction,
    input  wire logic       i_active_mode,
    input  wire logic       i_card_mode,
    input  wire logic [1:0] i_rate,
    input  wire logic       i_md_clear,
    // RF front end
    input  wire logic       i_ext_field,
    input  wire logic       i_sof_type_a,
    input  wire logic       i_sof_manch,
    input  wire logic       i_rx_reqa,
    input  wire logic       i_rx_sel_match,
    input  wire logic       i_rx_halt,
    // Data stream
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_valid,
    // Coding and role
    output nfcmc_cfg_t      o_cfg,
    output logic            o_role_initiator,
    output logic            o_level_det_en,
    output logic            o_rate_err,
    // Field handling
    output logic            o_init_start,
    output logic            o_external_field_error_interrupt,
    output logic [2:0]      o_field_status,
    // Card emulation
    output logic            o_resp_atqa,
    output logic            o_resp_sak,
    output logic            o_card_activated,
    // Mode detector
    output logic            o_md_valid,
    output nfcmc_md_t       o_md_result,
    // Data out
    output logic [7:0]      o_tx_data,
    output logic            o_tx_valid,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_valid
);

    localparam logic [15:0] CHK_LAST = 16'(CHECK_CYC - 1);

    if (CHECK_CYC < 1 || CHECK_CYC > 65536) begin : g_chk
        $error("CHECK_CYC out of range");
    end

    // ------------------------------------------------------------
    // External field synchroniser
    // ------------------------------------------------------------
    logic ext_m_q;
    logic ext_s_q;
    logic ext_d_q;
    logic ext_rise;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            ext_d_q <= 1'b0;
        end else begin
            ext_m_q <= i_ext_field;
            ext_s_q <= ext_m_q;
            ext_d_q <= ext_s_q;
        end
    end

    assign ext_rise = ext_s_q & ~ext_d_q;

    // ------------------------------------------------------------
    // Field-on sequencer
    // ------------------------------------------------------------
    nfcmc_fs_t   fs_q;
    nfcmc_fs_t   fs_d;
    logic [15:0] cnt_q;
    logic        fail;

    always_comb begin
        fs_d = fs_q;
        fail = 1'b0;
        unique case (fs_q)
            FS_OFF: begin
                // Host asks for initiator role explicitly
                if (i_field_on_instruction && i_init_request &&
                    !i_card_mode) begin
                    fs_d = FS_CHECK;
                end
            end
            FS_CHECK: begin
                if (ext_s_q) begin
                    fs_d = FS_OFF;
                    fail = 1'b1;
                end else if (cnt_q == CHK_LAST) begin
                    fs_d = FS_ON;
                end
            end
            FS_ON: begin
                if (i_field_off_instruction || !i_init_request) begin
                    fs_d = FS_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            fs_q <= FS_OFF;
        end else begin
            fs_q <= fs_d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst || fs_q != FS_CHECK) begin
            cnt_q <= CNT_RST;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_init_start                     <= 1'b0;
            o_external_field_error_interrupt <= 1'b0;
            o_field_status                   <= FIELD_STATUS_RST;
            o_role_initiator                 <= 1'b0;
            o_level_det_en                   <= 1'b1;
        end else begin
            o_init_start <= (fs_q == FS_CHECK) &&
                            (fs_d == FS_ON);
            o_external_field_error_interrupt <= fail;
            o_field_status[FST_OWN] <= (fs_d == FS_ON);
            o_field_status[FST_EXT] <= ext_s_q;
            // Error cause set wins over clear by a new instruction
            if (fail) begin
                o_field_status[FST_ERR] <= 1'b1;
            end else if (fs_q == FS_OFF && fs_d == FS_CHECK) begin
                o_field_status[FST_ERR] <= 1'b0;
            end
            o_role_initiator <= (fs_d == FS_ON);
            // Level detector never sleeps, even as initiator
            o_level_det_en <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Coding and modulation selection
    // ------------------------------------------------------------
    nfcmc_cfg_t cfg_d;
    logic       slow;

    always_comb begin
        cfg_d = '0;
        slow  = (i_rate != RATE_106);
        if (i_card_mode) begin
            // Type A answer at every card rate
            cfg_d.tx_code = CODE_MILLER;
            cfg_d.rx_code = CODE_MILLER;
            cfg_d.tx_mod  = MOD_LOAD;
        end else if (fs_q == FS_ON) begin
            cfg_d.tx_code   = slow ? CODE_MANCH : CODE_MILLER;
            cfg_d.rx_code   = slow ? CODE_MANCH : CODE_MILLER;
            cfg_d.tx_mod    = slow ? MOD_ASK_LOW : MOD_ASK100;
            cfg_d.own_field = 1'b1;
        end else begin
            cfg_d.rx_code = slow ? CODE_MANCH : CODE_MILLER;
            cfg_d.tx_code = slow ? CODE_MANCH : CODE_MILLER;
            if (i_active_mode) begin
                // Active target raises its field only while sending
                cfg_d.tx_mod    = slow ? MOD_ASK_LOW : MOD_ASK100;
                cfg_d.own_field = i_tx_valid;
            end else begin
                cfg_d.tx_mod = MOD_LOAD;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_cfg      <= '0;
            o_rate_err <= 1'b0;
        end else begin
            o_cfg      <= cfg_d;
            o_rate_err <= !i_card_mode && (i_rate == RATE_848);
        end
    end

    // ------------------------------------------------------------
    // Card emulation layer-3 activation
    // ------------------------------------------------------------
    nfcmc_cs_t cs_q;
    nfcmc_cs_t cs_d;

    always_comb begin
        cs_d = cs_q;
        unique case (cs_q)
            CS_IDLE: begin
                if (i_rx_reqa) begin
                    cs_d = CS_READY;
                end
            end
            CS_READY: begin
                if (i_rx_halt) begin
                    cs_d = CS_IDLE;
                end else if (i_rx_sel_match) begin
                    cs_d = CS_ACTIVE;
                end
            end
            CS_ACTIVE: begin
                // Later layers belong to the host
                if (i_rx_halt) begin
                    cs_d = CS_IDLE;
                end
            end
        endcase
        if (!i_card_mode || !ext_s_q) begin
            cs_d = CS_IDLE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cs_q             <= CS_IDLE;
            o_resp_atqa      <= 1'b0;
            o_resp_sak       <= 1'b0;
            o_card_activated <= 1'b0;
        end else begin
            cs_q        <= cs_d;
            o_resp_atqa <= (cs_q == CS_IDLE) && (cs_d == CS_READY);
            o_resp_sak  <= (cs_q == CS_READY) && (cs_d == CS_ACTIVE);
            o_card_activated <= (cs_q == CS_READY) &&
                                (cs_d == CS_ACTIVE);
        end
    end

    // ------------------------------------------------------------
    // Mode detector
    // ------------------------------------------------------------
    logic md_en;

    assign md_en = (fs_q == FS_OFF);

    always_ff @(posedge i_mclk) begin
        if (i_srst || ext_rise) begin
            o_md_valid  <= 1'b0;
            o_md_result <= '0;
        end else if (md_en && !o_md_valid &&
                     (i_sof_type_a || i_sof_manch)) begin
            // Type A wins if both patterns show at once
            o_md_valid         <= 1'b1;
            o_md_result.type_a <= i_sof_type_a;
            o_md_result.manch  <= !i_sof_type_a;
        end else if (i_md_clear) begin
            o_md_valid  <= 1'b0;
            o_md_result <= '0;
        end
    end

    // ------------------------------------------------------------
    // Data stream, sync byte untouched
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_tx_data  <= 8'h00;
            o_tx_valid <= 1'b0;
            o_rx_data  <= 8'h00;
            o_rx_valid <= 1'b0;
        end else begin
            o_tx_data  <= i_tx_data;
            o_tx_valid <= i_tx_valid;
            o_rx_data  <= i_rx_data;
            o_rx_valid <= i_rx_valid;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    property p_rate_err;
        !i_card_mode && i_rate == RATE_848 |=> o_rate_err;
    endproperty
    a_rate_err: assert property (p_rate_err)
        else $error("848 in peer mode not flagged");

    property p_slow_106;
        !i_card_mode && i_rate == RATE_106 |=>
            o_cfg.tx_code == CODE_MILLER && o_cfg.rx_code == CODE_MILLER;
    endproperty
    a_slow_106: assert property (p_slow_106)
        else $error("106 not Miller");

    property p_init_fast;
        !i_card_mode && fs_q == FS_ON && i_rate != RATE_106 |=>
            o_cfg.tx_code == CODE_MANCH && o_cfg.tx_mod == MOD_ASK_LOW;
    endproperty
    a_init_fast: assert property (p_init_fast)
        else $error("initiator fast coding wrong");

    property p_passive_tgt;
        !i_card_mode && fs_q != FS_ON && !i_active_mode &&
            i_rate != RATE_106 |=>
            o_cfg.tx_code == CODE_MANCH && o_cfg.tx_mod == MOD_LOAD;
    endproperty
    a_passive_tgt: assert property (p_passive_tgt)
        else $error("passive target answer wrong");

    property p_default_tgt;
        fs_q == FS_OFF |=> !o_role_initiator && o_level_det_en;
    endproperty
    a_default_tgt: assert property (p_default_tgt)
        else $error("not in target role with detector on");

    property p_quiet_check;
        $rose(fs_q == FS_ON) |->
            $past(fs_q) == FS_CHECK && $past(cnt_q) == CHK_LAST;
    endproperty
    a_quiet_check: assert property (p_quiet_check)
        else $error("field on without full check");

    property p_init_start;
        $rose(fs_q == FS_ON) |-> o_init_start ##1 !o_init_start;
    endproperty
    a_init_start: assert property (p_init_start)
        else $error("no init start pulse");

    property p_card_tx;
        i_card_mode |=> !o_rate_err && o_cfg.tx_mod == MOD_LOAD &&
            o_cfg.tx_code == CODE_MILLER;
    endproperty
    a_card_tx: assert property (p_card_tx)
        else $error("card answer not type A load");

    property p_activate;
        i_card_mode && ext_s_q && cs_q == CS_READY && i_rx_sel_match &&
            !i_rx_halt |=> cs_q == CS_ACTIVE;
    endproperty
    a_activate: assert property (p_activate)
        else $error("activation not completed");

    property p_act_evt;
        $rose(cs_q == CS_ACTIVE) |-> o_card_activated ##1 !o_card_activated;
    endproperty
    a_act_evt: assert property (p_act_evt)
        else $error("card activated event missing");

    property p_pass;
        i_tx_valid |=> o_tx_valid && o_tx_data == $past(i_tx_data);
    endproperty
    a_pass: assert property (p_pass)
        else $error("data byte altered");

    property p_md_manch;
        md_en && !o_md_valid && !ext_rise && i_sof_manch && !i_sof_type_a
            |=> o_md_valid && o_md_result.manch && !o_md_result.type_a;
    endproperty
    a_md_manch: assert property (p_md_manch)
        else $error("Manchester peer not classified");

    property p_act_tgt;
        !i_card_mode && i_active_mode && fs_q == FS_OFF && i_tx_valid
            |=> o_cfg.own_field && o_cfg.tx_mod != MOD_LOAD;
    endproperty
    a_act_tgt: assert property (p_act_tgt)
        else $error("active target without own field");

    property p_ext_err;
        fs_q == FS_CHECK && ext_s_q |=> o_external_field_error_interrupt &&
            o_field_status[FST_ERR] && fs_q == FS_OFF ##1 !o_cfg.own_field;
    endproperty
    a_ext_err: assert property (p_ext_err)
        else $error("external field error not handled");

    property p_md_hold;
        o_md_valid && !ext_rise && !i_md_clear |=>
            o_md_valid && $stable(o_md_result);
    endproperty
    a_md_hold: assert property (p_md_hold)
        else $error("mode result changed");

    c_field_on:  cover property ($rose(fs_q == FS_ON));
    c_ext_err:   cover property (o_external_field_error_interrupt);
    c_activated: cover property (o_card_activated);
    c_md_type_a: cover property (o_md_valid && o_md_result.type_a);

endmodule // nfcmc_core

// File: verif/nfcmc_peer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote peer: field level plus demodulator and framer events
// ------------------------------------------------------------
module nfcmc_peer (
    // Clock
    input  wire logic       i_mclk,
    // Toward the frontend
    output logic            o_ext_field,
    output logic [4:0]      o_evt
);
    // Event bits: {halt, select match, reqa, manchester sof, type a sof}
    initial begin
        o_ext_field = 1'b0;
        o_evt       = 5'h00;
    end

    // Field changes only when asked; no stray glitches between frames
    task automatic field(input logic on);
        @(negedge i_mclk);
        o_ext_field = on;
    endtask

    // Gap lets the same event come from a prompt or a slow peer
    task automatic pulse(input int gap, input logic [4:0] ev);
        repeat (gap) @(negedge i_mclk);
        @(negedge i_mclk);
        o_evt = ev;
        @(negedge i_mclk);
        o_evt = 5'h00;
    endtask
endmodule // nfcmc_peer

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
    import nfcmc_pkg::*;

    localparam int CHK   = 4;
    localparam int LIMIT = 3000;

    logic        i_mclk, i_srst, i_init_request, i_active_mode, i_card_mode;
    logic        i_field_on_instruction, i_field_off_instruction, i_md_clear;
    logic [1:0]  i_rate;
    logic [7:0]  i_tx_data, i_rx_data, o_tx_data, o_rx_data;
    logic        i_tx_valid, i_rx_valid, o_tx_valid, o_rx_valid;
    logic        ext_field;
    logic [4:0]  evt;
    nfcmc_cfg_t  o_cfg;
    nfcmc_md_t   o_md_result;
    logic [2:0]  o_field_status;
    logic        o_role_initiator, o_level_det_en, o_rate_err, o_init_start;
    logic        o_external_field_error_interrupt, o_resp_atqa, o_resp_sak;
    logic        o_card_activated, o_md_valid;
    int          num_errors, samples_checked;
    int          cyc = 0;
    int          n_atqa, n_act, n_err, n_init, n_role;
    logic [15:0] lfsr_q;
    logic [8:0]  q_tx[$], q_rx[$];
    logic [8:0]  exp_tx, exp_rx;

    nfcmc_core #(.CHECK_CYC(CHK)) dut (
        .i_mclk, .i_srst, .i_init_request, .i_field_on_instruction,
        .i_field_off_instruction, .i_active_mode, .i_card_mode, .i_rate,
        .i_md_clear, .i_ext_field(ext_field), .i_sof_type_a(evt[0]),
        .i_sof_manch(evt[1]), .i_rx_reqa(evt[2]), .i_rx_sel_match(evt[3]),
        .i_rx_halt(evt[4]), .i_tx_data, .i_tx_valid, .i_rx_data,
        .i_rx_valid, .o_cfg, .o_role_initiator, .o_level_det_en,
        .o_rate_err, .o_init_start, .o_external_field_error_interrupt,
        .o_field_status, .o_resp_atqa, .o_resp_sak, .o_card_activated,
        .o_md_valid, .o_md_result, .o_tx_data, .o_tx_valid, .o_rx_data,
        .o_rx_valid
    );
    nfcmc_peer peer (.i_mclk, .o_ext_field(ext_field), .o_evt(evt));

    // ------------------------------------------------------------
    // Reference model and compares
    // ------------------------------------------------------------
    function automatic nfcmc_cfg_t exp_cfg(int r, int a, int c, int ini);
        nfcmc_cfg_t e;
        e.tx_code = (c == 1 || r == 0) ? CODE_MILLER : CODE_MANCH;
        e.rx_code = e.tx_code;
        if (c == 1 || (a == 0 && ini == 0))
            e.tx_mod = MOD_LOAD;
        else
            e.tx_mod = (r == 0) ? MOD_ASK100 : MOD_ASK_LOW;
        e.own_field = (ini == 1);
        return e;
    endfunction

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction

    task automatic fail(input string m);
        num_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk_bit(input logic got, input logic exp, string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_byte(input logic [8:0] got, logic [8:0] exp, string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_cfg(input nfcmc_cfg_t got, nfcmc_cfg_t exp, string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask
    task automatic chk_cnt(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp) fail(m);
    endtask

    // Counts pulse cycles so width and count are judged, not just presence
    task automatic watch(input int n);
        {n_atqa, n_act, n_err, n_init, n_role} = '0;
        repeat (n) begin
            n_atqa += (o_resp_atqa === 1'b1);
            n_act  += (o_card_activated === 1'b1 && o_resp_sak === 1'b1);
            n_err  += (o_external_field_error_interrupt === 1'b1);
            n_init += (o_init_start === 1'b1);
            n_role += (o_role_initiator === 1'b1);
            @(negedge i_mclk);
        end
    endtask

    task automatic fon(input int r);
        i_rate = 2'(r);
        i_field_on_instruction = 1'b1;
        @(negedge i_mclk);
        i_field_on_instruction = 1'b0;
        for (int k = 1; k <= CHK + 1; k++) begin
            @(negedge i_mclk);
            chk_bit(o_init_start, k == CHK, "init start");
        end
        chk_bit(o_role_initiator, 1'b1, "role");
        chk_bit(o_field_status[FST_OWN], 1'b1, "own");
        chk_bit(o_field_status[FST_ERR], 1'b0, "err clr");
        @(negedge i_mclk);
        chk_cfg(o_cfg, exp_cfg(r, 0, 0, 1), "init");
        i_field_off_instruction = 1'b1;
        @(negedge i_mclk);
        i_field_off_instruction = 1'b0;
        @(negedge i_mclk);
        chk_bit(o_role_initiator, 1'b0, "role off");
    endtask

    task automatic done(input string name);
        $display("test %s done", name);
    endtask

    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fail("timeout");
            end_sim();
        end
    end

    initial begin
        {i_init_request, i_active_mode, i_card_mode, i_md_clear} = '0;
        {i_field_on_instruction, i_field_off_instruction, i_rate} = '0;
        {i_tx_valid, i_tx_data, i_rx_valid, i_rx_data} = '0;
        i_srst = 1'b1;
        lfsr_q = 16'h75bb;
        repeat (16) @(negedge i_mclk);
        chk_bit(o_level_det_en, 1'b1, "det in reset");
        chk_cfg(o_cfg, '0, "cfg in reset");
        i_srst = 1'b0;
        @(negedge i_mclk);
        chk_bit(o_level_det_en, 1'b1, "det");
        chk_bit(o_role_initiator, 1'b0, "target");
        done("reset");

        // Rate held per setting, as a transaction needs
        for (int c = 0; c < 2; c++)
            for (int a = 0; a < 2; a++)
                for (int r = 0; r < 4; r++) begin
                    i_card_mode = c[0];
                    i_active_mode = a[0];
                    i_rate = r[1:0];
                    repeat (2) @(negedge i_mclk);
                    chk_bit(o_rate_err, r == 3 && c == 0,
                            "rate");
                    if (r < 3 || c == 1)
                        chk_cfg(o_cfg, exp_cfg(r, a, c, 0),
                                "tgt");
                end
        {i_card_mode, i_rate} = '0;
        // Active target: own field must follow every sent byte
        i_active_mode = 1'b1;
        done("coding");

        for (int i = 0; i <= 24; i++) begin
            if (i > 0) begin
                exp_tx = q_tx.pop_front();
                exp_rx = q_rx.pop_front();
                chk_byte({o_tx_valid, o_tx_data}, exp_tx, "tx");
                chk_byte({o_rx_valid, o_rx_data}, exp_rx, "rx");
                chk_bit(o_cfg.own_field, exp_tx[8], "act tgt");
            end
            lfsr_q = lfsr(lfsr_q);
            {i_tx_valid, i_tx_data} =
                (i == 0) ? 9'h1f0 : lfsr_q[8:0];
            {i_rx_valid, i_rx_data} = (i == 1) ? 9'h1f0 : lfsr_q[15:7];
            q_tx.push_back({i_tx_valid, i_tx_data});
            q_rx.push_back({i_rx_valid, i_rx_data});
            @(negedge i_mclk);
        end
        {i_tx_valid, i_rx_valid, i_active_mode} = 3'h0;
        done("stream");

        i_init_request = 1'b1;
        peer.field(1'b1);
        repeat (3) @(negedge i_mclk);
        i_field_on_instruction = 1'b1;
        @(negedge i_mclk);
        i_field_on_instruction = 1'b0;
        watch(CHK + 4);
        chk_cnt(n_err, 1, "err pulse");
        chk_cnt(n_role + n_init, 0, "stayed off");
        chk_bit(o_field_status[FST_ERR], 1'b1, "err st");
        chk_bit(o_field_status[FST_EXT], 1'b1, "ext st");
        done("field error");

        i_card_mode = 1'b1;
        peer.pulse(1, 5'h02);
        repeat (2) @(negedge i_mclk);
        chk_byte({7'h00, o_md_valid, o_md_result.manch}, 9'h003,
                 "md");
        repeat (6) @(negedge i_mclk);
        chk_byte({7'h00, o_md_valid, o_md_result.manch}, 9'h003,
                 "hold");
        i_md_clear = 1'b1;
        @(negedge i_mclk);
        i_md_clear = 1'b0;
        repeat (2) @(negedge i_mclk);
        chk_bit(o_md_valid, 1'b0, "md clear");
        peer.pulse(0, 5'h03);
        repeat (2) @(negedge i_mclk);
        chk_byte({7'h00, o_md_result}, 9'h001, "type a wins");
        peer.field(1'b0);
        repeat (3) @(negedge i_mclk);
        peer.field(1'b1);
        repeat (4) @(negedge i_mclk);
        chk_bit(o_md_valid, 1'b0, "md new field");
        done("mode detector");

        peer.pulse(0, 5'h08);
        watch(4);
        chk_cnt(n_act, 0, "sel idle");
        peer.pulse(0, 5'h04);
        watch(3);
        chk_cnt(n_atqa, 1, "atqa");
        peer.pulse(2, 5'h08);
        watch(3);
        chk_cnt(n_act, 1, "activated");
        peer.pulse(0, 5'h10);
        peer.pulse(0, 5'h08);
        watch(4);
        chk_cnt(n_act, 0, "sel after halt");
        i_field_on_instruction = 1'b1;
        @(negedge i_mclk);
        i_field_on_instruction = 1'b0;
        watch(CHK + 4);
        chk_cnt(n_init + n_role + n_err, 0, "card refuses");
        done("card");

        i_card_mode = 1'b0;
        peer.field(1'b0);
        repeat (4) @(negedge i_mclk);
        for (int r = 0; r < 3; r++) fon(r);
        i_init_request = 1'b0;
        done("initiator");
        end_sim();
    end
endmodule // tb
